// ### rtl/mies_pkg.sv
// Notes on behaviour
// - subtract memory, result to accumulator, six flags
// - subtract memory, result back to memory
// - carry clear on borrow, set otherwise
// - subtract immediate into accumulator, six flags
// - nibble swap to memory or accumulator, no flags
// - skip-on-zero rewrites byte unchanged first
// - zero byte skips next, no flags
// - taken skip adds one dummy cycle
// - copy byte to accumulator, skip if zero
// - skip when selected bit is zero
// - table read via both pointers, high to latch
// - last-page table read via low pointer only
// - increment low pointer then page read
// - increment low pointer then last-page read
// - exclusive-or updates zero flag only
// - far forms reach full data memory
// - far add with carry, five flags
// - far add without carry, five flags
// - far and updates zero flag only
// - far clear byte or bit, no flags
// - far invert to memory or accumulator, zero flag
// - decimal adjust to memory, only carry
package mies_pkg;

    // ------------------------------------------------------------
    // operation codes presented by the sequencer
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        MIES_OP_NOP, MIES_OP_SUB_ACC, MIES_OP_SUB_MEM, MIES_OP_SUB_IMM,
        MIES_OP_SWAP_MEM, MIES_OP_SWAP_ACC, MIES_OP_SKIP_NULL, MIES_OP_COPY_SKIP,
        MIES_OP_BIT_SKIP, MIES_OP_TAB_PAGE, MIES_OP_TAB_LAST, MIES_OP_TAB_PAGE_INC,
        MIES_OP_TAB_LAST_INC, MIES_OP_XOR_ACC, MIES_OP_XOR_MEM, MIES_OP_XOR_IMM,
        MIES_OP_ADC_ACC, MIES_OP_ADC_MEM, MIES_OP_ADD_ACC, MIES_OP_ADD_MEM,
        MIES_OP_AND_ACC, MIES_OP_AND_MEM, MIES_OP_CLR_BYTE, MIES_OP_CLR_BIT,
        MIES_OP_INV_MEM, MIES_OP_INV_ACC, MIES_OP_BCD_ADJ
    } mies_op_type;

    // arithmetic status flags
    typedef struct packed {
        logic twos_wrap_flag;
        logic result_null_flag;
        logic half_carry_flag;
        logic unsigned_outflow_bit;
        logic signed_outflow_bit;
        logic chained_null_flag;
    } mies_flags_type;

    // one instruction request
    typedef struct packed {
        mies_op_type op;
        logic [2:0]  bit_sel;
        logic [7:0]  imm;
        logic [7:0]  mem_data;
        logic        far;
    } mies_req_type;

    // ------------------------------------------------------------
    // reset values and constants
    // ------------------------------------------------------------
    localparam logic [7:0]  MIES_ACC_RST   = 8'h00;
    localparam logic [7:0]  MIES_PTR_RST   = 8'h00;
    localparam logic [7:0]  MIES_LATCH_RST = 8'h00;
    localparam logic [5:0]  MIES_FLAG_RST  = 6'h00;
    localparam logic [3:0]  MIES_BCD_LIMIT = 4'h9;
    localparam logic [3:0]  MIES_BCD_STEP  = 4'h6;
    localparam logic [7:0]  MIES_BYTE_ZERO = 8'h00;
    localparam int          MIES_SKIP_DUMMY_CYCLES = 1;

endpackage : mies_pkg

// ### rtl/mies_execute.sv
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
module mies_execute #(
    parameter int PC_W   = 16,                         // program address width
    parameter int BANK_W = 1                           // bank bits added to the short data address
) (
    input  wire logic                 ref_clk,         // core clock 100 MHz
    input  wire logic                 nrst,            // async reset, active low
    input  wire mies_pkg::mies_req_type req,           // instruction request
    input  wire logic                 req_valid,       // request strobe, one cycle
    input  wire logic [7:0]           addr_in,         // short data address
    input  wire logic [BANK_W-1:0]    bank_in,         // current bank
    input  wire logic [BANK_W-1:0]    far_bank_in,     // bank from far operand
    input  wire logic [15:0]          prog_word,       // program word for table reads
    input  wire logic [7:0]           ptr_low_wdata,   // table_pointer_low load value
    input  wire logic                 ptr_low_we,      // table_pointer_low load strobe
    input  wire logic [7:0]           ptr_high_wdata,  // table_pointer_high load value
    input  wire logic                 ptr_high_we,     // table_pointer_high load strobe
    output logic [7:0]                accum,           // accumulator
    output mies_pkg::mies_flags_type  flags,           // status flags
    output logic [7:0]                mem_wdata,       // data memory write value
    output logic [BANK_W+7:0]         mem_waddr,       // full data memory address
    output logic                      mem_we,          // data memory write pulse
    output logic [PC_W-1:0]           tab_addr,        // program read address
    output logic [7:0]                table_pointer_low,
    output logic [7:0]                table_pointer_high,
    output logic [7:0]                table_latch_high,
    output logic                      skip_next,       // suppress next instruction, pulse
    output logic                      dummy_cycle      // inserted dummy cycle, pulse
);

    // ------------------------------------------------------------
    // combinational result path
    // ------------------------------------------------------------
    logic [7:0]  a, m, res;
    logic [8:0]  sum9;
    logic [4:0]  sum5;
    logic        to_mem, to_acc, arith, do_skip, is_sub, cin;
    mies_pkg::mies_flags_type fl_nxt;
    logic [7:0]  sub_b;                                // second operand after inversion
    logic        sub_c0;                               // carry into bit 0
    logic        tab_op;                               // any of the four table reads
    logic        tab_pend_r;                           // table word due on this edge
    logic [PC_W-1:0] tab_addr_nxt;
    logic [7:0]  bcd_v;
    logic        bcd_c;
    logic [7:0]  ptr_low_eff;

    assign a = accum;
    assign m = req.mem_data;

    // decimal adjust is its own function so the low and high steps read clearly
    function automatic logic [8:0] mies_bcd(input logic [7:0] v, input logic ac, input logic c);
        logic [8:0] t;
        t = {1'b0, v};
        if (v[3:0] > mies_pkg::MIES_BCD_LIMIT || ac)
            t = t + {5'h00, mies_pkg::MIES_BCD_STEP};
        if (t[7:4] > mies_pkg::MIES_BCD_LIMIT || c || t[8])
            t = t + {1'b0, mies_pkg::MIES_BCD_STEP, 4'h0};
        return t;
    endfunction : mies_bcd

    assign {bcd_c, bcd_v} = mies_bcd(a, flags.half_carry_flag, flags.unsigned_outflow_bit);

    assign tab_op = (req.op == mies_pkg::MIES_OP_TAB_PAGE ||
                     req.op == mies_pkg::MIES_OP_TAB_LAST ||
                     req.op == mies_pkg::MIES_OP_TAB_PAGE_INC ||
                     req.op == mies_pkg::MIES_OP_TAB_LAST_INC);

    // pre-increment shows on the address in the same cycle
    assign ptr_low_eff = (req.op == mies_pkg::MIES_OP_TAB_PAGE_INC ||
                          req.op == mies_pkg::MIES_OP_TAB_LAST_INC) ?
                         table_pointer_low + 8'h01 : table_pointer_low;

    always_comb begin
        fl_nxt  = flags;
        res     = m;
        to_mem  = 1'b0;
        to_acc  = 1'b0;
        arith   = 1'b0;
        is_sub  = 1'b0;
        cin     = 1'b0;
        do_skip = 1'b0;
        sum9    = 9'h000;
        sum5    = 5'h00;
        sub_b   = m;
        sub_c0  = 1'b0;
        case (req.op)
            mies_pkg::MIES_OP_SUB_ACC:  begin arith = 1'b1; is_sub = 1'b1; to_acc = 1'b1; end
            mies_pkg::MIES_OP_SUB_MEM:  begin arith = 1'b1; is_sub = 1'b1; to_mem = 1'b1; end
            mies_pkg::MIES_OP_SUB_IMM:  begin arith = 1'b1; is_sub = 1'b1; to_acc = 1'b1; end
            mies_pkg::MIES_OP_ADC_ACC:  begin arith = 1'b1; cin = flags.unsigned_outflow_bit; to_acc = 1'b1; end
            mies_pkg::MIES_OP_ADC_MEM:  begin arith = 1'b1; cin = flags.unsigned_outflow_bit; to_mem = 1'b1; end
            mies_pkg::MIES_OP_ADD_ACC:  begin arith = 1'b1; to_acc = 1'b1; end
            mies_pkg::MIES_OP_ADD_MEM:  begin arith = 1'b1; to_mem = 1'b1; end
            mies_pkg::MIES_OP_SWAP_MEM: begin res = {m[3:0], m[7:4]}; to_mem = 1'b1; end
            mies_pkg::MIES_OP_SWAP_ACC: begin res = {m[3:0], m[7:4]}; to_acc = 1'b1; end
            mies_pkg::MIES_OP_SKIP_NULL: begin
                res = m; to_mem = 1'b1;
                do_skip = (m == mies_pkg::MIES_BYTE_ZERO);
            end
            mies_pkg::MIES_OP_COPY_SKIP: begin
                res = m; to_acc = 1'b1;
                do_skip = (m == mies_pkg::MIES_BYTE_ZERO);
            end
            mies_pkg::MIES_OP_BIT_SKIP: do_skip = ~m[req.bit_sel];
            mies_pkg::MIES_OP_TAB_PAGE, mies_pkg::MIES_OP_TAB_LAST,
            mies_pkg::MIES_OP_TAB_PAGE_INC, mies_pkg::MIES_OP_TAB_LAST_INC: begin
                res = prog_word[7:0];
            end
            mies_pkg::MIES_OP_XOR_ACC: begin res = a ^ m; to_acc = 1'b1; end
            mies_pkg::MIES_OP_XOR_MEM: begin res = a ^ m; to_mem = 1'b1; end
            mies_pkg::MIES_OP_XOR_IMM: begin res = a ^ req.imm; to_acc = 1'b1; end
            mies_pkg::MIES_OP_AND_ACC: begin res = a & m; to_acc = 1'b1; end
            mies_pkg::MIES_OP_AND_MEM: begin res = a & m; to_mem = 1'b1; end
            mies_pkg::MIES_OP_CLR_BYTE: begin res = mies_pkg::MIES_BYTE_ZERO; to_mem = 1'b1; end
            mies_pkg::MIES_OP_CLR_BIT: begin
                res = m; res[req.bit_sel] = 1'b0; to_mem = 1'b1;
            end
            mies_pkg::MIES_OP_INV_MEM: begin res = ~m; to_mem = 1'b1; end
            mies_pkg::MIES_OP_INV_ACC: begin res = ~m; to_acc = 1'b1; end
            mies_pkg::MIES_OP_BCD_ADJ: begin
                res = bcd_v; to_mem = 1'b1;
                fl_nxt.unsigned_outflow_bit = bcd_c | flags.unsigned_outflow_bit;
            end
            default: ;
        endcase
        if (arith) begin
            // subtraction as a + ~b + 1 keeps carry meaning "no borrow"
            sub_b  = is_sub ? ~((req.op == mies_pkg::MIES_OP_SUB_IMM) ? req.imm : m) : m;
            sub_c0 = is_sub ? 1'b1 : cin;
            sum9 = {1'b0, a} + {1'b0, sub_b} + {8'h00, sub_c0};
            sum5 = {1'b0, a[3:0]} + {1'b0, sub_b[3:0]} + {4'h0, sub_c0};
            res  = sum9[7:0];
            fl_nxt.unsigned_outflow_bit = sum9[8];
            fl_nxt.half_carry_flag      = sum5[4];
            fl_nxt.twos_wrap_flag       = (a[7] == sub_b[7]) && (res[7] != a[7]);
            fl_nxt.signed_outflow_bit   = fl_nxt.twos_wrap_flag ^ res[7];
            fl_nxt.result_null_flag     = (res == mies_pkg::MIES_BYTE_ZERO);
            if (is_sub)
                fl_nxt.chained_null_flag = (res == mies_pkg::MIES_BYTE_ZERO) &&
                                           flags.chained_null_flag;
        end
        case (req.op)
            mies_pkg::MIES_OP_XOR_ACC, mies_pkg::MIES_OP_XOR_MEM, mies_pkg::MIES_OP_XOR_IMM,
            mies_pkg::MIES_OP_AND_ACC, mies_pkg::MIES_OP_AND_MEM,
            mies_pkg::MIES_OP_INV_MEM, mies_pkg::MIES_OP_INV_ACC:
                fl_nxt.result_null_flag = (res == mies_pkg::MIES_BYTE_ZERO);
            default: ;
        endcase
    end

    // ------------------------------------------------------------
    // accumulator and flags
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            accum <= mies_pkg::MIES_ACC_RST;
            flags <= mies_pkg::MIES_FLAG_RST;
        end else if (req_valid) begin
            if (to_acc)
                accum <= res;
            flags <= fl_nxt;
        end
    end

    // data memory write; far forms use their own bank, not the current one
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            mem_we    <= 1'b0;
            mem_wdata <= mies_pkg::MIES_BYTE_ZERO;
            mem_waddr <= '0;
        end else begin
            // a table read writes one cycle late, once the program word is back;
            // the sequencer must not issue a memory write in that cycle
            mem_we <= (req_valid && to_mem) || tab_pend_r;
            if (req_valid && (to_mem || tab_op))
                mem_waddr <= {req.far ? far_bank_in : bank_in, addr_in};
            if (tab_pend_r)
                mem_wdata <= prog_word[7:0];
            else if (req_valid && to_mem)
                mem_wdata <= res;
        end
    end

    // ------------------------------------------------------------
    // table pointers and latch
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            table_pointer_low  <= mies_pkg::MIES_PTR_RST;
            table_pointer_high <= mies_pkg::MIES_PTR_RST;
            table_latch_high   <= mies_pkg::MIES_LATCH_RST;
            tab_addr           <= '0;
            tab_pend_r         <= 1'b0;
        end else begin
            tab_pend_r <= req_valid && tab_op;
            if (req_valid && tab_op)
                tab_addr <= tab_addr_nxt;
            if (req_valid && (req.op == mies_pkg::MIES_OP_TAB_PAGE_INC ||
                              req.op == mies_pkg::MIES_OP_TAB_LAST_INC))
                table_pointer_low <= ptr_low_eff;
            else if (ptr_low_we)
                table_pointer_low <= ptr_low_wdata;
            if (ptr_high_we)
                table_pointer_high <= ptr_high_wdata;
            if (tab_pend_r)
                table_latch_high <= prog_word[15:8];
        end
    end

    // the program address is combinational from pointers, registered for the outputs
    always_comb begin
        if (req.op == mies_pkg::MIES_OP_TAB_LAST || req.op == mies_pkg::MIES_OP_TAB_LAST_INC)
            tab_addr_nxt = {{(PC_W-8){1'b1}}, ptr_low_eff};
        else
            tab_addr_nxt = {table_pointer_high[PC_W-9:0], ptr_low_eff};
    end

    // ------------------------------------------------------------
    // skip and dummy cycle
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            skip_next   <= 1'b0;
            dummy_cycle <= 1'b0;
        end else begin
            skip_next   <= req_valid && do_skip;
            dummy_cycle <= req_valid && do_skip;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_sub_carry_rule: assert property (@(posedge ref_clk) disable iff (!nrst)
        req_valid && req.op == mies_pkg::MIES_OP_SUB_ACC |=>
        flags.unsigned_outflow_bit == ($past(accum) >= $past(req.mem_data)))
        else $error("subtract carry wrong");
    a_sub_acc_val: assert property (@(posedge ref_clk) disable iff (!nrst)
        req_valid && req.op == mies_pkg::MIES_OP_SUB_ACC |=>
        accum == 8'($past(accum) - $past(req.mem_data)))
        else $error("subtract result wrong");
    a_swap_acc_val: assert property (@(posedge ref_clk) disable iff (!nrst)
        req_valid && req.op == mies_pkg::MIES_OP_SWAP_ACC |=>
        accum == {$past(req.mem_data[3:0]), $past(req.mem_data[7:4])} && $stable(flags))
        else $error("swap wrong");
    a_skip_null_wb: assert property (@(posedge ref_clk) disable iff (!nrst)
        req_valid && req.op == mies_pkg::MIES_OP_SKIP_NULL |=>
        mem_we && mem_wdata == $past(req.mem_data))
        else $error("skip rewrite missing");
    a_skip_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
        req_valid && req.op == mies_pkg::MIES_OP_SKIP_NULL |=>
        skip_next == ($past(req.mem_data) == 8'h00))
        else $error("skip decision wrong");
    a_skip_dummy: assert property (@(posedge ref_clk) disable iff (!nrst)
        skip_next |-> dummy_cycle ##1 !dummy_cycle)
        else $error("dummy cycle wrong");
    a_bit_skip: assert property (@(posedge ref_clk) disable iff (!nrst)
        req_valid && req.op == mies_pkg::MIES_OP_BIT_SKIP && !req.mem_data[req.bit_sel]
        |=> skip_next)
        else $error("bit skip missing");
    a_tab_latch: assert property (@(posedge ref_clk) disable iff (!nrst)
        req_valid && req.op == mies_pkg::MIES_OP_TAB_PAGE |=> ##1
        table_latch_high == $past(prog_word[15:8]) && mem_wdata == $past(prog_word[7:0]) &&
        mem_we)
        else $error("table read wrong");
    a_tab_preinc: assert property (@(posedge ref_clk) disable iff (!nrst)
        req_valid && req.op == mies_pkg::MIES_OP_TAB_PAGE_INC |=>
        table_pointer_low == 8'($past(table_pointer_low) + 8'h01))
        else $error("pre-increment missing");
    a_clr_noflag: assert property (@(posedge ref_clk) disable iff (!nrst)
        req_valid && req.op == mies_pkg::MIES_OP_CLR_BYTE |=> mem_wdata == 8'h00 && $stable(flags))
        else $error("clear wrong");

endmodule : mies_execute

// ### tb/mies_prog_model.sv
`timescale 1ns/10ps
module mies_prog_model (
    input  wire logic        ref_clk,    // core clock
    input  wire logic        mem_we,     // write pulse from the block
    input  wire logic [8:0]  mem_waddr,  // full data address
    input  wire logic [7:0]  mem_wdata,  // write value
    input  wire logic [15:0] tab_addr,   // program read address
    output logic      [15:0] prog_word   // program word at tab_addr
);
    logic [7:0] mem_r [0:511];
    // ------------------------------------------------------------
    // program memory: each byte depends on one half of the address, so a wrong
    // low pointer shows up in the latch and a wrong page in memory
    // ------------------------------------------------------------
    always_comb begin
        prog_word = {tab_addr[7:0] ^ 8'hA5, tab_addr[15:8] ^ 8'h3C};
    end
    // data memory keeps what the block writes
    always_ff @(posedge ref_clk) begin
        if (mem_we) begin
            mem_r[mem_waddr] <= mem_wdata;
        end
    end
endmodule : mies_prog_model

// ### tb/mies_execute_test.sv
`timescale 1ns/10ps
module mies_execute_test;
    logic                     ref_clk, nrst, req_valid, ptr_low_we, ptr_high_we, fr;
    mies_pkg::mies_req_type   req;
    mies_pkg::mies_flags_type flags;
    logic [7:0]               addr_in, ptr_low_wdata, ptr_high_wdata, accum, mem_wdata, tpl, tph, tlh;
    logic [0:0]               bank_in, far_bank_in;
    logic [15:0]              prog_word, tab_addr;
    logic [8:0]               mem_waddr;
    logic                     mem_we, skip_next, dummy_cycle;
    logic [5:0]               ef, km; // expected flags and which of them are known
    int                       n_errors, n_compared, cycles;

    mies_execute #(.PC_W(16), .BANK_W(1)) mies_execute_i (.ref_clk(ref_clk), .nrst(nrst),
        .req(req), .req_valid(req_valid), .addr_in(addr_in), .bank_in(bank_in),
        .far_bank_in(far_bank_in), .prog_word(prog_word), .ptr_low_wdata(ptr_low_wdata),
        .ptr_low_we(ptr_low_we), .ptr_high_wdata(ptr_high_wdata), .ptr_high_we(ptr_high_we),
        .accum(accum), .flags(flags), .mem_wdata(mem_wdata), .mem_waddr(mem_waddr),
        .mem_we(mem_we), .tab_addr(tab_addr), .table_pointer_low(tpl),
        .table_pointer_high(tph), .table_latch_high(tlh), .skip_next(skip_next),
        .dummy_cycle(dummy_cycle));
    mies_prog_model mies_prog_model_i (.ref_clk(ref_clk), .mem_we(mem_we),
        .mem_waddr(mem_waddr), .mem_wdata(mem_wdata), .tab_addr(tab_addr),
        .prog_word(prog_word));

    // ------------------------------------------------------------
    // clock, timeout and common tasks
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // a hang anywhere ends the run instead of stalling it
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one request, then sample just after the edge where the answer lands
    task automatic exec(input mies_pkg::mies_op_type op, input logic [7:0] m, input logic [7:0] x);
        @(posedge ref_clk);
        req       <= '{op: op, bit_sel: x[2:0], imm: x, mem_data: m, far: fr};
        req_valid <= 1'b1;
        @(posedge ref_clk);
        req_valid <= 1'b0;
        #1;
    endtask : exec
    function automatic logic [11:0] alu(input logic [7:0] a, input logic [7:0] b, input logic ci);
        logic [8:0] s;
        logic [4:0] h;
        s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        return {(a[7] == b[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s[8], s[7:0]};
    endfunction : alu
    // result in place, the other place untouched, flags as tracked
    task automatic res(input logic [7:0] v, input logic to_mem, input logic [7:0] a0);
        chk({7'h00, mem_we, to_mem ? mem_wdata : accum}, {7'h00, to_mem, v});
        if (to_mem) chk({accum, 7'h00, mem_waddr}, {a0, 7'h00, fr, 8'h40});
        chk({10'h000, flags & km}, {10'h000, ef & km});
    endtask : res
    task automatic arith(input logic [11:0] r, input logic to_mem, input logic [7:0] a0);
        ef[5:2] = r[11:8];
        km      = km & 6'h3D;
        res(r[7:0], to_mem, a0);
    endtask : arith
    task automatic lg(input logic [7:0] v, input logic to_mem, input logic [7:0] a0);
        ef[4] = (v == 8'h00);
        res(v, to_mem, a0);
    endtask : lg
    task automatic load(input logic [7:0] v);
        exec(mies_pkg::MIES_OP_COPY_SKIP, v, 8'h00);
        chk({accum, 7'h00, skip_next}, {v, 7'h00, v == 8'h00});
        chk({10'h000, flags & km}, {10'h000, ef & km});
    endtask : load

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_far();
        fr = 1'b1;
        load(8'h7F);
        exec(mies_pkg::MIES_OP_ADD_ACC, 8'h01, 8'h00);
        arith(alu(8'h7F, 8'h01, 1'b0), 1'b0, 8'h00);
        exec(mies_pkg::MIES_OP_ADC_MEM, 8'h80, 8'h00);
        arith(alu(8'h80, 8'h80, ef[2]), 1'b1, 8'h80);
        exec(mies_pkg::MIES_OP_ADC_ACC, 8'h0F, 8'h00);
        arith(alu(8'h80, 8'h0F, ef[2]), 1'b0, 8'h00);
        exec(mies_pkg::MIES_OP_ADD_MEM, 8'h70, 8'h00);
        arith(alu(8'h90, 8'h70, 1'b0), 1'b1, 8'h90);
        exec(mies_pkg::MIES_OP_AND_ACC, 8'hF0, 8'h00);
        lg(8'h90, 1'b0, 8'h00);
        exec(mies_pkg::MIES_OP_AND_MEM, 8'h0F, 8'h00);
        lg(8'h00, 1'b1, 8'h90);
        exec(mies_pkg::MIES_OP_CLR_BYTE, 8'h5A, 8'h00);
        res(8'h00, 1'b1, 8'h90);
        exec(mies_pkg::MIES_OP_CLR_BIT, 8'hFF, 8'h03);
        res(8'hF7, 1'b1, 8'h90);
        exec(mies_pkg::MIES_OP_INV_MEM, 8'hFF, 8'h00);
        lg(8'h00, 1'b1, 8'h90);
        exec(mies_pkg::MIES_OP_INV_ACC, 8'h0F, 8'h00);
        lg(8'hF0, 1'b0, 8'h00);
        load(8'h9A);
        exec(mies_pkg::MIES_OP_BCD_ADJ, 8'h00, 8'h00);
        km = km & 6'h3B;                                // carry rule left open
        res(8'h00, 1'b1, 8'h9A);
        fr = 1'b0;
    endtask : t_far
    task automatic t_sub();
        load(8'h10);
        exec(mies_pkg::MIES_OP_SUB_ACC, 8'h20, 8'h00);
        km = 6'h3C;
        arith(alu(8'h10, 8'hDF, 1'b1), 1'b0, 8'h00);
        exec(mies_pkg::MIES_OP_SUB_IMM, 8'h00, 8'hF0);
        arith(alu(8'hF0, 8'h0F, 1'b1), 1'b0, 8'h00);
        exec(mies_pkg::MIES_OP_SUB_MEM, 8'h01, 8'h00);
        arith(alu(8'h00, 8'hFE, 1'b1), 1'b1, 8'h00);
        exec(mies_pkg::MIES_OP_XOR_IMM, 8'h00, 8'h3C);
        lg(8'h3C, 1'b0, 8'h00);
        exec(mies_pkg::MIES_OP_XOR_ACC, 8'h3C, 8'h00);
        lg(8'h00, 1'b0, 8'h00);
        exec(mies_pkg::MIES_OP_XOR_MEM, 8'h81, 8'h00);
        lg(8'h81, 1'b1, 8'h00);
    endtask : t_sub
    task automatic t_swap_skip();
        logic d;
        exec(mies_pkg::MIES_OP_SWAP_MEM, 8'h3C, 8'h00);
        res(8'hC3, 1'b1, 8'h00);
        exec(mies_pkg::MIES_OP_SWAP_ACC, 8'h3C, 8'h00);
        res(8'hC3, 1'b0, 8'h00);
        for (int z = 0; z < 2; z++) begin
            exec(mies_pkg::MIES_OP_SKIP_NULL, z ? 8'h07 : 8'h00, 8'h00);
            res(z ? 8'h07 : 8'h00, 1'b1, 8'hC3);
            chk({15'h0000, skip_next}, {15'h0000, z == 0});
            d = dummy_cycle;
            @(posedge ref_clk);
            #1;
            chk({30'h0, d, dummy_cycle}, {30'h0, z == 0, 1'b0});
        end
        load(8'h00);
        for (int i = 0; i < 16; i++) begin
            exec(mies_pkg::MIES_OP_BIT_SKIP, i[3] ? ~(8'h01 << i[2:0]) : 8'h01 << i[2:0], i[7:0]);
            chk({15'h0000, skip_next}, {15'h0000, i[3]});
        end
    endtask : t_swap_skip
    task automatic t_table();
        logic [15:0] a;
        @(posedge ref_clk);
        {ptr_low_we, ptr_high_we, ptr_low_wdata, ptr_high_wdata} <= {2'b11, 16'hFE12};
        @(posedge ref_clk);
        {ptr_low_we, ptr_high_we} <= 2'b00;
        for (int k = 0; k < 4; k++) begin
            exec(mies_pkg::mies_op_type'(int'(mies_pkg::MIES_OP_TAB_PAGE) + k), 8'h00, 8'h00);
            @(posedge ref_clk);
            #1;
            a = {k[0] ? 8'hFF : 8'h12, 8'hFE + {6'h00, k[1] & k[0], k[1] & ~k[0]}};
            chk({mem_wdata, tlh}, {a[15:8] ^ 8'h3C, a[7:0] ^ 8'hA5});
            chk(tpl, a[7:0]);
        end
    endtask : t_table

    initial begin
        {nrst, req_valid, ptr_low_we, ptr_high_we, fr} = 5'b00000;
        req = '0;
        {addr_in, bank_in, far_bank_in} = {8'h40, 1'b0, 1'b1};
        {ptr_low_wdata, ptr_high_wdata} = 16'h0000;
        {ef, km} = {6'h00, 6'h3F};
        repeat (20) @(posedge ref_clk);
        nrst <= 1'b1;
        #1;
        chk({accum, 2'b00, flags}, 16'h0000);
        t_far();
        t_sub();
        t_swap_skip();
        t_table();
        end_of_test();
    end
endmodule : mies_execute_test
